// ==== design/rbc_pkg.sv ====
// package: register bit-cell types, field layout and reset values for the register cell bank
package rbc_pkg;
   // access kinds a single bit cell can be built as
   typedef enum logic [2:0] {
      RBC_RO, RBC_RC, RBC_WO, RBC_W1C, RBC_LL, RBC_LH, RBC_SC, RBC_RSV
   } rbc_kind_t;

   // register word width, as one management word of 16 bits
   localparam int RBC_WORD_W = 16;
   // address width of the local register window
   localparam int RBC_ADDR_W = 8;
   // source port codes for the access arbiter
   localparam logic [1:0] RBC_SRC_MGMT = 2'h0;
   localparam logic [1:0] RBC_SRC_INBAND = 2'h1;
   localparam logic [1:0] RBC_SRC_MIIM = 2'h2;
   // reset value of the write-only control cells and their ctrl_o copy
   localparam logic [15:0] RBC_RESET_VAL = 16'h0000;
   // value driven for write-only and reserved bits on a read
   localparam logic RBC_UNDEF_BIT = 1'b0;
   // base of the phy register window; reads there return zero, with no error flag
   localparam logic [7:0] RBC_PHY_BASE = 8'h80;

   // one register access request from any management source
   typedef struct packed {
      logic valid;
      logic write;
      logic [RBC_ADDR_W-1:0] addr;
      logic [RBC_WORD_W-1:0] wdata;
   } rbc_req_t;

   // one register access answer
   typedef struct packed {
      logic valid;
      logic [RBC_WORD_W-1:0] rdata;
   } rbc_rsp_t;
endpackage

// ==== design/rbc_cell.sv ====
// one register bit cell with a configurable access kind
module rbc_cell #(
   parameter rbc_pkg::rbc_kind_t KIND = rbc_pkg::RBC_RO,
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic wr_i,
   input wire logic wdata_i,
   input wire logic rd_i,
   input wire logic hw_i,
   output logic value_o,
   output logic rdata_o
);
   logic cell_ff; // stored state of the cell
   logic nxt_cell; // next stored state
   logic latched_ff; // latch engaged, holds captured level

   // latch capture event: status departs from its idle level
   wire logic ll_event = (KIND == rbc_pkg::RBC_LL) && !hw_i;
   wire logic lh_event = (KIND == rbc_pkg::RBC_LH) && hw_i;

   // next state per kind
   always_comb begin
      nxt_cell = cell_ff;
      case (KIND)
         rbc_pkg::RBC_RO: nxt_cell = hw_i;
         rbc_pkg::RBC_RC: begin
            // set wins over the read clear; writes ignored
            if (hw_i) nxt_cell = 1'b1;
            else if (rd_i) nxt_cell = 1'b0;
         end
         rbc_pkg::RBC_WO: if (wr_i) nxt_cell = wdata_i;
         rbc_pkg::RBC_W1C: begin
            if (hw_i) nxt_cell = 1'b1;
            else if (wr_i && wdata_i) nxt_cell = 1'b0;
         end
         rbc_pkg::RBC_LL: begin
            // hold low while latched, else follow status
            if (ll_event) nxt_cell = 1'b0;
            else if (!latched_ff || rd_i) nxt_cell = hw_i;
         end
         rbc_pkg::RBC_LH: begin
            if (lh_event) nxt_cell = 1'b1;
            else if (!latched_ff || rd_i) nxt_cell = hw_i;
         end
         rbc_pkg::RBC_SC: begin
            // a one write sets for one cycle; a zero write is ignored
            if (wr_i && wdata_i) nxt_cell = 1'b1;
            else nxt_cell = 1'b0;
         end
         default: nxt_cell = 1'b0;
      endcase
   end

   // state and latch flops; latch kinds ignore writes (read-only)
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cell_ff <= RESET_VAL;
         latched_ff <= 1'b0;
      end else begin
         cell_ff <= nxt_cell;
         // new event wins over the releasing read
         if (ll_event || lh_event) latched_ff <= 1'b1;
         else if (rd_i) latched_ff <= 1'b0;
      end
   end

   assign value_o = cell_ff;
   // write-only and reserved cells give undefined (zero) data
   assign rdata_o = (KIND == rbc_pkg::RBC_WO || KIND == rbc_pkg::RBC_RSV) ?
                    rbc_pkg::RBC_UNDEF_BIT : cell_ff;
endmodule

// ==== design/rbc_bank.sv ====
// register bank built from bit cells, shared by management, in-band and miim access
// What this block does
// - read-only bits ignore every write
// - read-to-clear bits clear after read, ignore writes
// - write-only bits store writes, read undefined
// - writing one clears, writing zero keeps
// - latch-low holds low until host reads
// - latch-high holds high until host reads
// - read releases latch; bit follows status again
// - latching applies only to read-only status bits
// - self-clearing bits return to zero themselves
// - all registers reachable from management and in-band
// - phy registers reachable over miim
module rbc_bank #(
   parameter int NREG = 4
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire rbc_pkg::rbc_req_t mgmt_req_i,
   input wire rbc_pkg::rbc_req_t inband_req_i,
   input wire rbc_pkg::rbc_req_t miim_req_i,
   input wire logic [15:0] status_i,
   input wire logic [15:0] event_i,
   output rbc_pkg::rbc_rsp_t mgmt_rsp_o,
   output rbc_pkg::rbc_rsp_t inband_rsp_o,
   output rbc_pkg::rbc_rsp_t miim_rsp_o,
   output logic [15:0] ctrl_o,
   output logic [15:0] cmd_o
);
   // register layout, by index:
   // 0 control  : bits 15:0 write-only control
   // 1 command  : bits 15:0 self-clearing
   // 2 status   : 7:0 latch-high, 15:8 latch-low, of status_i
   // 3 events   : 7:0 read-to-clear, 15:8 write-one-clear, of event_i
   // others (and phy window from RBC_PHY_BASE) read zero, write ignored
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_CMD = 8'h01;
   localparam logic [7:0] IDX_STAT = 8'h02;
   localparam logic [7:0] IDX_EVT = 8'h03;

   // synchronised status and event inputs, from outside the domain
   logic [15:0] stat_s1_ff, stat_s2_ff;
   logic [15:0] evt_s1_ff, evt_s2_ff;

   // two-flop synchronisers; first stage only feeds second
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_s1_ff <= 16'h0000;
         stat_s2_ff <= 16'h0000;
         evt_s1_ff <= 16'h0000;
         evt_s2_ff <= 16'h0000;
      end else begin
         stat_s1_ff <= status_i;
         stat_s2_ff <= stat_s1_ff;
         evt_s1_ff <= event_i;
         evt_s2_ff <= evt_s1_ff;
      end
   end

   // fixed priority grant; management first, in-band, then miim
   function automatic logic [1:0] pick_src(input logic m, input logic b);
      if (m) return rbc_pkg::RBC_SRC_MGMT;
      else if (b) return rbc_pkg::RBC_SRC_INBAND;
      else return rbc_pkg::RBC_SRC_MIIM;
   endfunction

   // address match helper, used by every register strobe
   function automatic logic hit(input rbc_pkg::rbc_req_t r, input logic [7:0] idx);
      return r.valid && (r.addr == idx);
   endfunction

   // one access per cycle; others wait (requester offers again)
   wire logic [1:0] src = pick_src(mgmt_req_i.valid, inband_req_i.valid);
   wire rbc_pkg::rbc_req_t req = (src == rbc_pkg::RBC_SRC_MGMT) ? mgmt_req_i :
                                 (src == rbc_pkg::RBC_SRC_INBAND) ? inband_req_i :
                                 miim_req_i;
   // miim reaches only the phy window and the status register
   wire logic miim_ok = (src != rbc_pkg::RBC_SRC_MIIM) || (req.addr >= rbc_pkg::RBC_PHY_BASE)
                        || (req.addr == IDX_STAT);
   wire logic acc = req.valid && miim_ok;
   wire logic rd_any = acc && !req.write;
   wire logic wr_any = acc && req.write;
   wire rbc_pkg::rbc_req_t acc_req = '{valid: acc, write: req.write, addr: req.addr,
                                       wdata: req.wdata};

   // per-register strobes
   wire logic wr_ctrl = wr_any && hit(acc_req, IDX_CTRL);
   wire logic wr_cmd = wr_any && hit(acc_req, IDX_CMD);
   wire logic wr_evt = wr_any && hit(acc_req, IDX_EVT);
   wire logic rd_stat = rd_any && hit(acc_req, IDX_STAT);
   wire logic rd_evt = rd_any && hit(acc_req, IDX_EVT);

   wire logic [15:0] ctrl_v, ctrl_r, cmd_v, cmd_r, stat_v, stat_r, evt_v, evt_r;

   // cell arrays for each register
   for (genvar i = 0; i < 16; i++) begin : g_cells
      rbc_cell #(.KIND(rbc_pkg::RBC_WO), .RESET_VAL(rbc_pkg::RBC_RESET_VAL[i])) u_ctrl (
         .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_i(wr_ctrl),
         .wdata_i(req.wdata[i]), .rd_i(1'b0), .hw_i(1'b0),
         .value_o(ctrl_v[i]), .rdata_o(ctrl_r[i]));
      rbc_cell #(.KIND(rbc_pkg::RBC_SC), .RESET_VAL(1'b0)) u_cmd (
         .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_i(wr_cmd),
         .wdata_i(req.wdata[i]), .rd_i(1'b0), .hw_i(1'b0),
         .value_o(cmd_v[i]), .rdata_o(cmd_r[i]));
      // latch kinds only on read-only status; write strobe tied off
      rbc_cell #(.KIND(i < 8 ? rbc_pkg::RBC_LH : rbc_pkg::RBC_LL), .RESET_VAL(1'b0)) u_stat (
         .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_i(1'b0),
         .wdata_i(1'b0), .rd_i(rd_stat), .hw_i(stat_s2_ff[i]),
         .value_o(stat_v[i]), .rdata_o(stat_r[i]));
      rbc_cell #(.KIND(i < 8 ? rbc_pkg::RBC_RC : rbc_pkg::RBC_W1C), .RESET_VAL(1'b0)) u_evt (
         .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_i(wr_evt),
         .wdata_i(req.wdata[i]), .rd_i(rd_evt), .hw_i(evt_s2_ff[i]),
         .value_o(evt_v[i]), .rdata_o(evt_r[i]));
   end

   // read data mux; unmapped and reserved read zero
   wire logic [15:0] rd_mux = (req.addr == IDX_CTRL) ? ctrl_r :
                              (req.addr == IDX_CMD) ? cmd_r :
                              (req.addr == IDX_STAT) ? stat_r :
                              (req.addr == IDX_EVT) ? evt_r : 16'h0000;

   // answer registers, one per source
   rbc_pkg::rbc_rsp_t mgmt_rsp_ff, inband_rsp_ff, miim_rsp_ff;
   logic [15:0] ctrl_ff, cmd_ff;

   // answer one cycle after the access is taken
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mgmt_rsp_ff <= '0;
         inband_rsp_ff <= '0;
         miim_rsp_ff <= '0;
      end else begin
         mgmt_rsp_ff <= '{valid: req.valid && src == rbc_pkg::RBC_SRC_MGMT,
                          rdata: rd_any ? rd_mux : 16'h0000};
         inband_rsp_ff <= '{valid: req.valid && src == rbc_pkg::RBC_SRC_INBAND,
                            rdata: rd_any ? rd_mux : 16'h0000};
         // refused miim access still answers, with zero data
         miim_rsp_ff <= '{valid: req.valid && src == rbc_pkg::RBC_SRC_MIIM,
                          rdata: rd_any ? rd_mux : 16'h0000};
      end
   end

   // outward control copies, straight from flops
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_ff <= rbc_pkg::RBC_RESET_VAL;
         cmd_ff <= 16'h0000;
      end else begin
         ctrl_ff <= ctrl_v;
         cmd_ff <= cmd_v;
      end
   end

   assign mgmt_rsp_o = mgmt_rsp_ff;
   assign inband_rsp_o = inband_rsp_ff;
   assign miim_rsp_o = miim_rsp_ff;
   assign ctrl_o = ctrl_ff;
   assign cmd_o = cmd_ff;

   // assertions
   property p_sc_clears;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      wr_cmd |=> ##1 (cmd_v == 16'h0000 || $past(wr_cmd));
   endproperty
   a_sc_clears: assert property (p_sc_clears) else $error("sc bit did not clear");

   property p_sc_zero_noeffect;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_cmd && req.wdata == 16'h0000) |=> cmd_v == 16'h0000;
   endproperty
   a_sc_zero_noeffect: assert property (p_sc_zero_noeffect) else $error("sc zero write set bit");

   property p_wo_takes;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      wr_ctrl |=> ##1 ctrl_o == $past(req.wdata, 2);
   endproperty
   a_wo_takes: assert property (p_wo_takes) else $error("control write not taken");

   property p_lh_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (stat_v[0] && !rd_stat) |=> stat_v[0];
   endproperty
   a_lh_hold: assert property (p_lh_hold) else $error("latch-high released without read");

   property p_ll_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!stat_v[8] && !rd_stat) |=> !stat_v[8];
   endproperty
   a_ll_hold: assert property (p_ll_hold) else $error("latch-low released without read");

   property p_rel_follow;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_stat && !stat_s2_ff[0]) |=> !stat_v[0];
   endproperty
   a_rel_follow: assert property (p_rel_follow) else $error("latch not released by read");

   property p_event_wins;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_stat && stat_s2_ff[0]) |=> stat_v[0];
   endproperty
   a_event_wins: assert property (p_event_wins) else $error("coinciding event lost");

   property p_rc_clear;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_evt && !evt_s2_ff[2]) |=> !evt_v[2];
   endproperty
   a_rc_clear: assert property (p_rc_clear) else $error("read-to-clear kept value");

   property p_w1c;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_evt && !req.wdata[13] && evt_v[13]) |=> evt_v[13];
   endproperty
   a_w1c: assert property (p_w1c) else $error("zero write cleared w1c bit");

   property p_answer;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (mgmt_req_i.valid) |=> mgmt_rsp_o.valid;
   endproperty
   a_answer: assert property (p_answer) else $error("management access not answered");

   // command write taken with at least one bit set
   sequence s_cmd_taken;
      wr_cmd && (req.wdata != 16'h0000);
   endsequence

   // no further command write in the following cycle
   sequence s_cmd_quiet;
      !wr_cmd;
   endsequence

   // outward pulse carries the written bits, two cycles after the take
   property p_cmd_out;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      s_cmd_taken |=> ##1 cmd_o == $past(req.wdata, 2);
   endproperty
   a_cmd_out: assert property (p_cmd_out) else $error("command pulse lost");

   // outward pulse lasts a single cycle when no new write follows
   property p_cmd_gone;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      s_cmd_taken ##1 s_cmd_quiet |=> ##1 cmd_o == 16'h0000;
   endproperty
   a_cmd_gone: assert property (p_cmd_gone) else $error("command pulse stuck");

   // control cells keep their value between writes
   property p_ctrl_keep;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !wr_ctrl |=> $stable(ctrl_v);
   endproperty
   a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed without write");

   // a one write clears a write-one-clear bit once its event is gone
   property p_w1c_clear;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_evt && req.wdata[13] && !evt_s2_ff[13]) |=> !evt_v[13];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("one write did not clear");

   // writes leave read-to-clear bits alone
   property p_rc_write_inert;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_evt && evt_v[0]) |=> evt_v[0];
   endproperty
   a_rc_write_inert: assert property (p_rc_write_inert) else $error("write cleared rc bit");

   // an event during the clearing read stays captured
   property p_rc_event_wins;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_evt && evt_s2_ff[0]) |=> evt_v[0];
   endproperty
   a_rc_event_wins: assert property (p_rc_event_wins) else $error("read event lost");

   // latch-low captures a low status level at once
   property p_ll_capture;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !stat_s2_ff[8] |=> !stat_v[8];
   endproperty
   a_ll_capture: assert property (p_ll_capture) else $error("latch-low missed low level");

   // a read with status high lets latch-low follow again
   property p_ll_release;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_stat && stat_s2_ff[8]) |=> stat_v[8];
   endproperty
   a_ll_release: assert property (p_ll_release) else $error("latch-low not released");

   // lower source waits while management holds the grant
   property p_grant_order;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (mgmt_req_i.valid && inband_req_i.valid) |=> !inband_rsp_o.valid;
   endproperty
   a_grant_order: assert property (p_grant_order) else $error("in-band answered while waiting");

   // refused miim write leaves control untouched
   property p_miim_refused;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (src == rbc_pkg::RBC_SRC_MIIM && req.valid && req.write && !miim_ok)
         |=> $stable(ctrl_v);
   endproperty
   a_miim_refused: assert property (p_miim_refused) else $error("refused miim write landed");

   // a lone miim access always answers, refused or not
   property p_miim_answer;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (miim_req_i.valid && !mgmt_req_i.valid && !inband_req_i.valid) |=> miim_rsp_o.valid;
   endproperty
   a_miim_answer: assert property (p_miim_answer) else $error("miim access not answered");
endmodule

// ==== sim/rbc_host_model.sv ====
// host model: one management access at a time on one request port of the bank
module rbc_host_model (
   input wire logic clk_sys_i,
   output rbc_pkg::rbc_req_t req_o,
   input wire rbc_pkg::rbc_rsp_t rsp_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle until the first access
   initial req_o = '0;
   // offer for one edge, look for the answer one edge later, offer again if no answer came
   // one edge per offer, because a held level would be taken twice
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      int tries;
      logic done;
      tries = 0;
      done = 1'b0;
      // unknown until an answer is seen, so a give-up shows in any compare
      q = 16'hxxxx;
      while (!done && tries < 16) begin
         @(posedge clk_sys_i);
         // callers write zeros to unused fields
         req_o <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
         @(posedge clk_sys_i);
         // released lines show the inverse, never the last value
         req_o <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
         @(posedge clk_sys_i);
         // answer taken at the edge it is seen; write-only data is not trusted
         if (rsp_i.valid === 1'b1) begin
            q = rsp_i.rdata;
            done = 1'b1;
         end
         tries++;
      end
   endtask
endmodule

// ==== sim/register_bit_access_cells_test.sv ====
// testbench for the register cell bank with host models on all three access ports
module register_bit_access_cells_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0; // 50 mhz system clock
   logic reset_n_i = 1'b0; // active low reset
   logic [15:0] status_i = 16'hff00; // live status, latch-low half idles high
   logic [15:0] event_i = 16'h0000; // event levels
   rbc_pkg::rbc_req_t mgmt_req, inband_req, miim_req; // host requests
   rbc_pkg::rbc_rsp_t mgmt_rsp, inband_rsp, miim_rsp; // bank answers
   logic [15:0] ctrl, cmd; // control copy and command pulses
   logic [15:0] qm, qi, qn; // read data per port
   int bad_count = 0;
   int checks = 0;
   // clock, 20 ns period
   always #10 clk_sys_i = ~clk_sys_i;
   rbc_bank rbc_bank_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .mgmt_req_i(mgmt_req), .inband_req_i(inband_req), .miim_req_i(miim_req),
      .status_i(status_i), .event_i(event_i), .mgmt_rsp_o(mgmt_rsp),
      .inband_rsp_o(inband_rsp), .miim_rsp_o(miim_rsp), .ctrl_o(ctrl), .cmd_o(cmd));
   // three host models, one per source; names carry the port since there are three
   rbc_host_model rbc_host_model_mgmt_inst (.clk_sys_i(clk_sys_i), .req_o(mgmt_req),
      .rsp_i(mgmt_rsp));
   rbc_host_model rbc_host_model_inband_inst (.clk_sys_i(clk_sys_i), .req_o(inband_req),
      .rsp_i(inband_rsp));
   rbc_host_model rbc_host_model_miim_inst (.clk_sys_i(clk_sys_i), .req_o(miim_req),
      .rsp_i(miim_rsp));
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic give_verdict();
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // idle cycles
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // management port shorthand
   task automatic mx(input logic wr, input logic [7:0] a, input logic [15:0] d);
      rbc_host_model_mgmt_inst.xfer(wr, a, d, qm);
      // unknown data means the model gave up waiting for an answer
      if (wr) check(16'(qm === 16'hxxxx), 16'h0000);
   endtask
   // write the command word and count cycles the pulse shows
   task automatic cmd_pulse(input logic [15:0] d, input int exp_n);
      int n;
      n = 0;
      fork
         mx(1'b1, 8'h01, d);
         repeat (8) begin
            @(posedge clk_sys_i);
            // any bit seen must be a written bit
            if (cmd !== 16'h0000) begin
               n++;
               check(cmd, d);
            end
         end
      join
      check(16'(n), 16'(exp_n));
      check(cmd, 16'h0000);
   endtask
   // outputs quiet after reset
   task automatic t_reset();
      check(ctrl, 16'h0000);
      check(cmd, 16'h0000);
      check({15'h0000, mgmt_rsp.valid}, 16'h0000);
   endtask
   // write-only control reaches ctrl_o, reads back as zero
   task automatic t_control();
      mx(1'b1, 8'h00, 16'h00a5);
      wait_n(3);
      check(ctrl, 16'h00a5);
      mx(1'b0, 8'h00, 16'h0000);
      check(qm, 16'h0000);
   endtask
   // self-clearing command: one pulse, reads zero, zero write is inert
   task automatic t_command();
      cmd_pulse(16'h0003, 1);
      mx(1'b0, 8'h01, 16'h0000);
      check(qm, 16'h0000);
      cmd_pulse(16'h0000, 0);
   endtask
   // latch-high and latch-low capture and release
   task automatic t_status();
      mx(1'b0, 8'h02, 16'h0000);
      wait_n(4);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff00);
      status_i <= 16'hfe01;
      wait_n(3);
      status_i <= 16'hff00;
      wait_n(5);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hfe01);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff00);
      mx(1'b1, 8'h02, 16'hffff);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff00);
      // latch-high event still present while the host reads
      status_i <= 16'hff01;
      wait_n(4);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff01);
      status_i <= 16'hff00;
      wait_n(4);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff01);
      mx(1'b0, 8'h02, 16'h0000);
      check(qm, 16'hff00);
   endtask
   // read-to-clear and write-one-to-clear events, event racing a read
   task automatic t_event();
      event_i <= 16'hffff;
      wait_n(3);
      event_i <= 16'h0000;
      wait_n(5);
      mx(1'b1, 8'h03, 16'h0f0f);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'hf0ff);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'hf000);
      mx(1'b1, 8'h03, 16'h0000);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'hf000);
      mx(1'b1, 8'h03, 16'hf000);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'h0000);
      event_i <= 16'h0001;
      wait_n(4);
      mx(1'b0, 8'h03, 16'h0000);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'h0001);
      event_i <= 16'h0000;
      wait_n(5);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'h0001);
      mx(1'b0, 8'h03, 16'h0000);
      check(qm, 16'h0000);
   endtask
   // in-band and miim reach, refused miim targets, arbitration
   task automatic t_ports();
      rbc_host_model_inband_inst.xfer(1'b1, 8'h00, 16'h5a5a, qi);
      wait_n(3);
      check(ctrl, 16'h5a5a);
      rbc_host_model_inband_inst.xfer(1'b0, 8'h02, 16'h0000, qi);
      check(qi, 16'hff00);
      rbc_host_model_miim_inst.xfer(1'b0, 8'h02, 16'h0000, qn);
      check(qn, 16'hff00);
      rbc_host_model_miim_inst.xfer(1'b1, 8'h00, 16'h1234, qn);
      wait_n(3);
      check(ctrl, 16'h5a5a);
      rbc_host_model_miim_inst.xfer(1'b0, 8'h81, 16'h0000, qn);
      check(qn, 16'h0000);
      fork
         mx(1'b1, 8'h00, 16'h0011);
         rbc_host_model_inband_inst.xfer(1'b0, 8'h02, 16'h0000, qi);
      join
      wait_n(3);
      check(ctrl, 16'h0011);
      check(qi, 16'hff00);
   endtask
   // main sequence
   initial begin
      wait_n(12);
      reset_n_i <= 1'b1;
      wait_n(1);
      t_reset();
      t_control();
      t_command();
      t_status();
      t_event();
      t_ports();
      give_verdict();
   end
   // watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      #100us;
      bad_count++;
      give_verdict();
   end
endmodule
